// ---- inc/sensor_mode_regs.vh ----
// Constants for the sensor system mode controller
//----------------------------------------------------------------
// Function
// - Supply below power-on level keeps device off, all blocks down, bus silent.
// - Standby powers digital only, analog and clocks stopped, registers still accessible.
// - Active runs digital and analog blocks and keeps serving register accesses.
// - Going from active to standby clears no register.
// - Going from standby to active resets a defined register subset only.
// - Wake and sleep are sub-states of active, not separate power states.
// - Device never holds the serial clock line low.
// - Output scaled 4096, 2048, 1024 counts per g for 2, 4, 8 g.
// - Acceleration outputs are two's complement, zero g at range centre.
// - Self-test output is real acceleration plus test offset scaled by range.
`ifndef SENSOR_MODE_REGS_VH
`define SENSOR_MODE_REGS_VH

//----------------------------------------------------------------
// Mode status codes
//----------------------------------------------------------------
`define MODE_STANDBY    2'h0
`define MODE_WAKE       2'h1
`define MODE_SLEEP      2'h2
`define MODE_OFF        2'h3

//----------------------------------------------------------------
// Full-scale range codes and reset values for range and self-test
//----------------------------------------------------------------
`define RANGE_2G        2'h0
`define RANGE_4G        2'h1
`define RANGE_8G        2'h2
`define RANGE_RSVD      2'h3
`define RANGE_RESET     2'h0
`define SELF_TEST_RESET 1'h0

//----------------------------------------------------------------
// Sample widths
//----------------------------------------------------------------
`define RAW_W           18
`define SAMPLE_W        14
`define SAMPLE_RESET    14'h0000

`endif

// ---- rtl/sample_scaler.v ----
// Range scaling and self-test summing of one acceleration sample
`timescale 1ns/10ps
`include "sensor_mode_regs.vh"

module sample_scaler #(
	parameter RAW_W = `RAW_W,
	parameter OUT_W = `SAMPLE_W
) (
	input  wire signed [RAW_W-1:0] raw_accel,
	input  wire signed [RAW_W-1:0] zero_g_offset,
	input  wire signed [RAW_W-1:0] st_force,
	input  wire                    self_test_on,
	input  wire        [1:0]       range_sel,
	output wire        [OUT_W-1:0] sample
);

	localparam SUM_W = RAW_W + 2;

	//----------------------------------------------------------------
	// Saturation to the output code range
	//----------------------------------------------------------------
	function [OUT_W-1:0] saturate;
		input signed [SUM_W-1:0] v;
		reg signed [SUM_W-1:0] hi;
		reg signed [SUM_W-1:0] lo;
		begin
			hi = {{(SUM_W-OUT_W+1){1'b0}}, {(OUT_W-1){1'b1}}};
			lo = ~hi;
			if (v > hi) begin
				saturate = {1'b0, {(OUT_W-1){1'b1}}};
			end else if (v < lo) begin
				saturate = {1'b1, {(OUT_W-1){1'b0}}};
			end else begin
				saturate = v[OUT_W-1:0];
			end
		end
	endfunction

	wire signed [SUM_W-1:0] force_term;
	wire signed [SUM_W-1:0] sum;
	reg  signed [SUM_W-1:0] scaled;

	// Test force simply adds; its size in counts then follows the range
	assign force_term = self_test_on ? {{2{st_force[RAW_W-1]}}, st_force} : {SUM_W{1'b0}};
	assign sum = {{2{raw_accel[RAW_W-1]}}, raw_accel}
		+ {{2{zero_g_offset[RAW_W-1]}}, zero_g_offset} + force_term;

	always @* begin
		case (range_sel)
			`RANGE_2G: scaled = sum;
			`RANGE_4G: scaled = sum >>> 1;
			`RANGE_8G: scaled = sum >>> 2;
			default: scaled = sum;
		endcase
	end

	assign sample = saturate(scaled);

endmodule

// ---- rtl/sensor_mode_ctrl.v ----
// System mode control, power gating and sample output of the motion sensor
`timescale 1ns/10ps
`include "sensor_mode_regs.vh"

module sensor_mode_ctrl #(
	parameter RAW_W = `RAW_W,
	parameter OUT_W = `SAMPLE_W
) (
	input  wire                    clk_sys,
	input  wire                    rst_n,
	input  wire                    supply_ok,
	input  wire                    host_active_req,
	input  wire                    sleep_req,
	input  wire                    cfg_wr,
	input  wire        [1:0]       cfg_range,
	input  wire                    cfg_self_test,
	input  wire                    raw_valid,
	input  wire signed [RAW_W-1:0] raw_accel,
	input  wire signed [RAW_W-1:0] zero_g_offset,
	input  wire signed [RAW_W-1:0] st_force,
	output reg         [1:0]       system_mode_state,
	output reg                     bus_enable,
	output reg                     scl_oe,
	output reg                     digital_enable,
	output reg                     analog_enable,
	output reg                     clock_enable,
	output reg         [1:0]       range_sel,
	output reg                     self_test_on,
	output reg         [OUT_W-1:0] sample,
	output reg                     sample_ready,
	output reg                     reg_restore
);

	//----------------------------------------------------------------
	// Mode sequencer
	//----------------------------------------------------------------
	localparam ST_OFF     = 2'h0;
	localparam ST_STANDBY = 2'h1;
	localparam ST_WAKE    = 2'h2;
	localparam ST_SLEEP   = 2'h3;

	reg  [1:0]       state;
	reg  [1:0]       next_state;
	wire [OUT_W-1:0] next_sample;
	wire [3:0]       next_power;
	reg  [1:0]       next_range_sel;
	reg              next_self_test;
	reg  [OUT_W-1:0] next_sample_word;
	reg              next_sample_ready;
	reg              next_reg_restore;

	function is_active;
		input [1:0] s;
		begin
			is_active = (s == ST_WAKE) || (s == ST_SLEEP);
		end
	endfunction

	function [1:0] mode_code;
		input [1:0] s;
		begin
			case (s)
				ST_STANDBY: mode_code = `MODE_STANDBY;
				ST_WAKE: mode_code = `MODE_WAKE;
				ST_SLEEP: mode_code = `MODE_SLEEP;
				default: mode_code = `MODE_OFF;
			endcase
		end
	endfunction

	//----------------------------------------------------------------
	// Power decode: bus, digital, analog and clock enables
	//----------------------------------------------------------------
	// One table keeps the four enables consistent per state
	function [3:0] power_map;
		input [1:0] s;
		begin
			case (s)
				ST_OFF: power_map = 4'h0;
				ST_STANDBY: power_map = 4'hc;
				ST_WAKE: power_map = 4'hf;
				ST_SLEEP: power_map = 4'hf;
				default: power_map = 4'h0;
			endcase
		end
	endfunction

	always @* begin
		next_state = state;
		case (state)
			ST_OFF: begin
				next_state = ST_STANDBY;
			end
			ST_STANDBY: begin
				if (host_active_req) begin
					next_state = sleep_req ? ST_SLEEP : ST_WAKE;
				end
			end
			ST_WAKE, ST_SLEEP: begin
				if (!host_active_req) begin
					next_state = ST_STANDBY;
				end else begin
					next_state = sleep_req ? ST_SLEEP : ST_WAKE;
				end
			end
			default: next_state = ST_OFF;
		endcase
		// Supply loss overrides any host request
		if (!supply_ok) begin
			next_state = ST_OFF;
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			state <= ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	//----------------------------------------------------------------
	// Power and clock gating outputs
	//----------------------------------------------------------------
	// Outputs follow next_state so the mode and the enables change together
	assign next_power = power_map(next_state);

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			system_mode_state <= `MODE_OFF;
			bus_enable        <= 1'b0;
			digital_enable    <= 1'b0;
			analog_enable     <= 1'b0;
			clock_enable      <= 1'b0;
			scl_oe            <= 1'b0;
		end else begin
			system_mode_state <= mode_code(next_state);
			bus_enable        <= next_power[3];
			digital_enable    <= next_power[2];
			analog_enable     <= next_power[1];
			clock_enable      <= next_power[0];
			// Master owns clock timing; no stretching, so never drive low
			scl_oe            <= 1'b0;
		end
	end

	//----------------------------------------------------------------
	// Configuration registers
	//----------------------------------------------------------------
	// Writes are accepted in standby and active; a reserved range is ignored
	always @* begin
		next_range_sel = range_sel;
		next_self_test = self_test_on;
		if (next_state == ST_OFF) begin
			// Config is volatile, so losing supply drops it
			next_range_sel = `RANGE_RESET;
			next_self_test = `SELF_TEST_RESET;
		end else if (cfg_wr && state != ST_OFF) begin
			if (cfg_range != `RANGE_RSVD) begin
				next_range_sel = cfg_range;
			end
			next_self_test = cfg_self_test;
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			range_sel    <= `RANGE_RESET;
			self_test_on <= `SELF_TEST_RESET;
		end else begin
			range_sel    <= next_range_sel;
			self_test_on <= next_self_test;
		end
	end

	//----------------------------------------------------------------
	// Sample path
	//----------------------------------------------------------------
	sample_scaler #(
		.RAW_W         (RAW_W),
		.OUT_W         (OUT_W)
	) u_scaler (
		.raw_accel     (raw_accel),
		.zero_g_offset (zero_g_offset),
		.st_force      (st_force),
		.self_test_on  (self_test_on),
		.range_sel     (range_sel),
		.sample        (next_sample)
	);

	// Sample and ready form the subset restored on entry to active;
	// config survives, so a host need not reprogram after standby
	always @* begin
		next_sample_word  = sample;
		next_sample_ready = sample_ready;
		next_reg_restore  = 1'b0;
		if (state == ST_OFF) begin
			next_sample_word  = `SAMPLE_RESET;
			next_sample_ready = 1'b0;
		end else if (state == ST_STANDBY && is_active(next_state)) begin
			next_sample_word  = `SAMPLE_RESET;
			next_sample_ready = 1'b0;
			next_reg_restore  = 1'b1;
		end else if (is_active(state) && raw_valid) begin
			// Leaving active for standby touches nothing; sampling just stops with the clocks
			next_sample_word  = next_sample;
			next_sample_ready = 1'b1;
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			sample       <= `SAMPLE_RESET;
			sample_ready <= 1'b0;
			reg_restore  <= 1'b0;
		end else begin
			sample       <= next_sample_word;
			sample_ready <= next_sample_ready;
			reg_restore  <= next_reg_restore;
		end
	end

endmodule

// ---- dv/sensor_host_model.sv ----
// Host model issuing mode and config requests
`timescale 1ns/10ps
module sensor_host_model (
	input            clk_sys,
	output reg       host_active_req = 1'b0,
	output reg       sleep_req = 1'b0,
	output reg       cfg_wr = 1'b0,
	output reg [1:0] cfg_range = 2'h0,
	output reg       cfg_self_test = 1'b0
);
	task set_mode(input a, input s);
		begin
			@(negedge clk_sys);
			host_active_req = a;
			sleep_req = s;
		end
	endtask
	task wr_cfg(input [1:0] r, input st);
		begin
			@(negedge clk_sys);
			cfg_wr = 1'b1;
			cfg_range = r;
			cfg_self_test = st;
			@(negedge clk_sys);
			cfg_wr = 1'b0;
			// Stale field would hide a late sample
			cfg_range = ~r;
		end
	endtask
endmodule

// ---- dv/sensor_mode_ctrl_checker.sv ----
// Port assertions for the mode controller
`timescale 1ns/10ps
`include "sensor_mode_regs.vh"
module sensor_mode_ctrl_checker #(parameter OUT_W = `SAMPLE_W) (
	input             clk_sys, rst_n, supply_ok, host_active_req, cfg_wr,
	input [1:0]       cfg_range, system_mode_state, range_sel,
	input             bus_enable, scl_oe, digital_enable, analog_enable, clock_enable,
	input             sample_ready, reg_restore,
	input [OUT_W-1:0] sample
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire stby = system_mode_state == `MODE_STANDBY;
	wire act = system_mode_state == `MODE_WAKE || system_mode_state == `MODE_SLEEP;
	property p_off; !supply_ok |=> system_mode_state == `MODE_OFF && !bus_enable
		&& !digital_enable && !analog_enable; endproperty
	a_off: assert property (p_off) else $error("off bad");
	property p_stby; stby |-> bus_enable && digital_enable && !analog_enable && !clock_enable;
	endproperty
	a_stby: assert property (p_stby) else $error("standby bad");
	property p_act; act |-> bus_enable && digital_enable && analog_enable && clock_enable;
	endproperty
	a_act: assert property (p_act) else $error("active bad");
	property p_scl; !scl_oe; endproperty
	a_scl: assert property (p_scl) else $error("scl held");
	property p_keep; stby ##1 stby |-> $stable(sample) && $stable(sample_ready); endproperty
	a_keep: assert property (p_keep) else $error("sample lost");
	property p_wake; stby && supply_ok && host_active_req |=> act && reg_restore
		&& sample == 0 && !sample_ready ##1 !reg_restore; endproperty
	a_wake: assert property (p_wake) else $error("wake bad");
	property p_req; supply_ok && !host_active_req && system_mode_state != `MODE_OFF |=> stby;
	endproperty
	a_req: assert property (p_req) else $error("no standby");
	property p_rng; cfg_wr && cfg_range != 2'h3 && supply_ok && system_mode_state != `MODE_OFF
		|=> range_sel == $past(cfg_range); endproperty
	a_rng: assert property (p_rng) else $error("range bad");
endmodule
bind sensor_mode_ctrl sensor_mode_ctrl_checker #(.OUT_W(OUT_W)) chk_i (.*);

// ---- dv/test_sensor_system_mode_control.sv ----
// Self-checking bench for the mode controller
`timescale 1ns/10ps
`include "sensor_mode_regs.vh"
module test_sensor_system_mode_control;
	reg               clk_sys, rst_n, supply_ok, raw_valid;
	reg signed [17:0] raw_accel, zero_g_offset, st_force;
	wire              host_active_req, sleep_req, cfg_wr, cfg_self_test;
	wire [1:0]        cfg_range, system_mode_state, range_sel;
	wire              bus_enable, digital_enable, analog_enable, clock_enable;
	wire              self_test_on, sample_ready;
	wire [13:0]       sample;
	integer n_mismatch = 0, compares = 0, seed = 8838, m_range = 0, m_st = 0, exp_s, i, r;
	sensor_host_model host_i (.*);
	sensor_mode_ctrl sensor_mode_ctrl_i (.*, .scl_oe(), .reg_restore());
	task chk(input string nm, input [31:0] e, input [31:0] s);
		begin
			compares++;
			if (s !== e) begin
				n_mismatch++;
				$display("FAIL %0s exp %0h got %0h", nm, e, s);
			end
		end
	endtask
	task print_verdict;
		begin
			$display("compares %0d mismatches %0d", compares, n_mismatch);
			if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
			else $display("CHECKS NOT OK");
			$finish;
		end
	endtask
	initial begin
		clk_sys = 0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// Run needs about 136 cycles
	initial begin
		#100000;
		n_mismatch++;
		print_verdict;
	end
	initial begin
		rst_n = 0; supply_ok = 1; raw_valid = 0; raw_accel = 0; zero_g_offset = 0; st_force = 0;
		repeat (16) @(negedge clk_sys);
		rst_n = 1;
		repeat (2) @(negedge clk_sys);
		chk("mode", `MODE_STANDBY, system_mode_state);
		for (r = 0; r < 4; r++) begin
			host_i.wr_cfg(r, 0);
			if (r != 3) m_range = r;
			chk("range", m_range, range_sel);
		end
		$display("config test done");
		host_i.set_mode(1, 0);
		@(negedge clk_sys);
		chk("mode", `MODE_WAKE, system_mode_state);
		chk("sample", 0, sample);
		chk("ready", 0, sample_ready);
		for (i = 0; i < 24; i++) begin
			r = $random(seed) & 3;
			m_st = $random(seed) & 1;
			host_i.wr_cfg(r, m_st);
			if (r != 3) m_range = r;
			host_i.set_mode(1, i & 1);
			raw_valid = 1;
			raw_accel = $random(seed) % 131072;
			zero_g_offset = $random(seed) % 512;
			st_force = $random(seed) % 2048;
			@(negedge clk_sys);
			raw_valid = 0;
			exp_s = (raw_accel + zero_g_offset + (m_st ? st_force : 0)) >>> m_range;
			if (exp_s > 8191) exp_s = 8191;
			if (exp_s < -8192) exp_s = -8192;
			chk("sample", exp_s[13:0], sample);
			chk("ready", 1, sample_ready);
			chk("self_test", m_st, self_test_on);
			chk("analog", 1, analog_enable);
			chk("mode", (i & 1) ? `MODE_SLEEP : `MODE_WAKE, system_mode_state);
		end
		$display("sample test done");
		host_i.set_mode(0, 0);
		repeat (3) @(negedge clk_sys);
		chk("sample", exp_s[13:0], sample);
		chk("mode", `MODE_STANDBY, system_mode_state);
		chk("analog", 0, analog_enable);
		chk("clock", 0, clock_enable);
		chk("digital", 1, digital_enable);
		host_i.set_mode(1, 1);
		@(negedge clk_sys);
		chk("mode", `MODE_SLEEP, system_mode_state);
		chk("sample", 0, sample);
		chk("ready", 0, sample_ready);
		chk("range", m_range, range_sel);
		host_i.set_mode(0, 0);
		repeat (2) @(negedge clk_sys);
		chk("mode", `MODE_STANDBY, system_mode_state);
		$display("standby test done");
		supply_ok = 0;
		@(negedge clk_sys);
		chk("mode", `MODE_OFF, system_mode_state);
		chk("bus", 0, bus_enable);
		chk("digital", 0, digital_enable);
		supply_ok = 1;
		repeat (2) @(negedge clk_sys);
		chk("range", 0, range_sel);
		chk("self_test", 0, self_test_on);
		$display("off test done");
		print_verdict;
	end
endmodule
